// ==== hw/path_overhead_monitor.sv ====
// Receive path overhead monitor: trace, parity, label and status bytes
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module path_overhead_monitor
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Byte stream and upstream indications
   input wire poh_monitor_pkg::poh_in_s poh,
   input wire logic latch_event,
   input wire logic path_ais,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Transmit side overhead requests
   output logic [3:0] tx_rei_count,
   output logic tx_rdi_request
);

   // Adds with saturation at sixteen bits
   function automatic logic [15:0] add_sat(input logic [15:0] a, input logic [3:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {13'h0000, b};
      add_sat = s[16] ? 16'hffff : s[15:0];
   endfunction

   // Counts set bits of a byte
   function automatic logic [3:0] ones(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
      begin
         n = n + {3'h0, v[i]};
      end
      ones = n;
   endfunction

   // Software registers
   poh_monitor_pkg::ctrl_s ctrl_r; // Mode and option bits
   logic [7:0] exp_label_r; // Expected signal label
   logic [poh_monitor_pkg::DELTA_W-1:0] delta_r; // Sticky change bits
   logic [15:0] rdata_r; // Read data, one cycle after strobe
   logic [7:0] store_r [poh_monitor_pkg::TRACE_LEN]; // Trace capture store

   // Common strobes
   wire logic sdh = ctrl_r.sdh;
   wire logic [7:0] pd = poh.data;
   wire logic j1_sonet = ~sdh & poh.j1;
   wire logic j1_sdh = sdh & poh.j1;
   logic latch_prev_r;
   wire logic latch_edge = latch_event & ~latch_prev_r;

   // SONET capture
   poh_monitor_pkg::cap_state_e cap_state_r;
   logic cap_req_prev_r; // Last request bit, for edge detection
   logic [6:0] cap_cnt_r; // Bytes shifted in, saturating at 64
   wire logic cap_start = ~sdh & ctrl_r.capture & ~cap_req_prev_r;
   wire logic cap_shift = j1_sonet & (cap_state_r == poh_monitor_pkg::CAP_RUN);
   wire logic [6:0] cap_cnt_inc = (cap_cnt_r == poh_monitor_pkg::TRACE_LEN_CNT) ?
                                  cap_cnt_r : cap_cnt_r + 7'h01;
   wire logic cap_tail = (store_r[poh_monitor_pkg::TRACE_LEN-1] == poh_monitor_pkg::TRACE_CR)
                         & (pd == poh_monitor_pkg::TRACE_LF);
   wire logic cap_done = cap_shift & (cap_cnt_inc == poh_monitor_pkg::TRACE_LEN_CNT)
                         & (~ctrl_r.delim | cap_tail);

   // SDH trace framer and acceptance
   poh_monitor_pkg::tf_state_e tf_state_r;
   logic [3:0] zero_run_r; // Consecutive zero MSBs while searching
   logic [3:0] tf_pos_r; // Byte position in frame, marker is 0
   logic tf_err_r; // MSB error seen in current frame
   logic [1:0] bad_cnt_r; // Consecutive errored frames
   logic [1:0] same_cnt_r; // Consecutive identical frames
   logic [127:0] cur_frame_r; // Frame being assembled, store order
   logic [127:0] prev_frame_r; // Last complete frame
   logic [127:0] frame_nxt; // Current frame with this byte added
   logic [127:0] store_lo; // Entries 0..15 of the store, packed
   logic tf_oof_r; // Trace out-of-frame flag
   wire logic in_sync = (tf_state_r == poh_monitor_pkg::TF_SYNC);
   wire logic msb_err = (tf_pos_r == 4'h0) ? ~pd[7] : pd[7];
   wire logic err_acc = tf_err_r | msb_err;
   wire logic frame_end = j1_sdh & in_sync & (tf_pos_r == 4'hf);
   wire logic go_sync = j1_sdh & ~in_sync & pd[7]
                        & (zero_run_r == poh_monitor_pkg::SDH_ZERO_RUN);
   wire logic [1:0] bad_nxt = err_acc ? bad_cnt_r + 2'h1 : 2'h0;
   wire logic lose_sync = frame_end & (bad_nxt == poh_monitor_pkg::SDH_BAD_FRAMES);
   wire logic frame_same = (frame_nxt == prev_frame_r);
   wire logic [1:0] same_nxt = ~frame_same ? 2'h1 :
                               (same_cnt_r == poh_monitor_pkg::SDH_SAME_FRAMES) ?
                               same_cnt_r : same_cnt_r + 2'h1;
   wire logic sdh_accept = frame_end & (same_nxt == poh_monitor_pkg::SDH_SAME_FRAMES);
   wire logic tf_oof_nxt = sdh & ~(in_sync & ~lose_sync | go_sync);

   // Place this byte into the frame; marker lands at entry 15
   always_comb
   begin
      frame_nxt = cur_frame_r;
      frame_nxt[{tf_pos_r - 4'h1, 3'h0} +: 8] = pd;
      for (int i = 0; i < 16; i++)
      begin
         store_lo[8*i +: 8] = store_r[i];
      end
   end

   // Path parity
   logic [7:0] bip_acc_r; // Parity of the frame in progress
   logic [7:0] bip_prev_r; // Parity of the previous frame
   logic acc_ok_r; // Accumulation began on a J1 byte
   logic prev_ok_r; // Previous-frame parity is complete
   logic [15:0] b3_cnt_r; // Running parity error total
   logic [15:0] b3_count_r; // Latched parity error total
   logic [3:0] rei_r; // Last B3 mismatch count
   wire logic b3_chk = poh.b3 & prev_ok_r;
   wire logic [3:0] b3_err = b3_chk ? ones(pd ^ bip_prev_r) : 4'h0;

   // Signal label
   logic [7:0] c2_last_r; // Last received label
   logic [2:0] c2_cnt_r; // Consecutive identical labels
   logic [7:0] label_r; // Accepted signal label
   logic plm_r; // Label mismatch flag
   logic uneq_r; // Unequipped flag
   logic rdi_req_r; // Transmit RDI request
   wire logic c2_same = (pd == c2_last_r);
   wire logic [2:0] c2_cnt_nxt = ~c2_same ? 3'h1 :
                                 (c2_cnt_r == poh_monitor_pkg::LABEL_FRAMES) ?
                                 c2_cnt_r : c2_cnt_r + 3'h1;
   wire logic c2_accept = poh.c2 & (c2_cnt_nxt == poh_monitor_pkg::LABEL_FRAMES);
   wire logic exempt = (label_r == poh_monitor_pkg::LABEL_UNEQ)
                       | (label_r == poh_monitor_pkg::LABEL_EQUIP)
                       | (label_r == poh_monitor_pkg::LABEL_PDI)
                       | (label_r == poh_monitor_pkg::LABEL_RSVD);
   wire logic plm_w = (label_r != exp_label_r) & ~exempt;
   wire logic uneq_w = (label_r == poh_monitor_pkg::LABEL_UNEQ)
                       & (exp_label_r != 8'h00);

   // Path status byte
   logic [15:0] rei_cnt_r; // Running remote error total
   logic [15:0] rei_count_r; // Latched remote error total
   logic [2:0] rdi_last_r; // Last monitored value
   logic [3:0] rdi_cnt_r; // Consecutive identical values
   logic [2:0] rdi_acc_r; // Accepted G1 bits 5..7
   logic [2:0] on_cnt_r; // Frames carrying RDI
   logic [2:0] off_cnt_r; // Frames with bits 5 and 6 clear
   logic rdi_def_r; // Path RDI defect
   wire logic [3:0] g1_rei = (poh.g1 & (pd[7:4] <= poh_monitor_pkg::REI_MAX)) ?
                             pd[7:4] : 4'h0;
   wire logic [2:0] rdi_mon = ctrl_r.rdi_sel ? {pd[3], 2'h0} : pd[3:1];
   wire logic [3:0] rdi_cnt_nxt = (rdi_mon != rdi_last_r) ? 4'h1 :
                                  (rdi_cnt_r == 4'hf) ? rdi_cnt_r : rdi_cnt_r + 4'h1;
   wire logic [3:0] persist = (ctrl_r.persist == 4'h0) ? 4'h1 : ctrl_r.persist;
   wire logic rdi_accept = poh.g1 & (rdi_cnt_nxt >= persist);
   wire logic rdi_diff = ctrl_r.rdi_sel ? (pd[3] != rdi_acc_r[2])
                                        : (pd[3:1] != rdi_acc_r);
   wire logic def_step = poh.g1 & ~sdh & ~path_ais;
   wire logic [2:0] on_nxt = ~pd[3] ? 3'h0 :
                             (on_cnt_r == poh_monitor_pkg::RDI_DEFECT_FRAMES) ?
                             on_cnt_r : on_cnt_r + 3'h1;
   wire logic [2:0] off_nxt = (pd[3:2] != 2'h0) ? 3'h0 :
                              (off_cnt_r == poh_monitor_pkg::RDI_DEFECT_FRAMES) ?
                              off_cnt_r : off_cnt_r + 3'h1;

   // Delta set and clear; a set in the clearing cycle wins
   logic [poh_monitor_pkg::DELTA_W-1:0] delta_set;
   always_comb
   begin
      delta_set = '0;
      delta_set[poh_monitor_pkg::DL_AVAIL] = cap_done;
      delta_set[poh_monitor_pkg::DL_OOF] = (tf_oof_nxt != tf_oof_r);
      delta_set[poh_monitor_pkg::DL_TRACE] = sdh_accept & (frame_nxt != store_lo);
      delta_set[poh_monitor_pkg::DL_LABEL] = c2_accept & (pd != label_r);
      delta_set[poh_monitor_pkg::DL_PLM] = (plm_w != plm_r);
      delta_set[poh_monitor_pkg::DL_UNEQ] = (uneq_w != uneq_r);
      delta_set[poh_monitor_pkg::DL_RDI] = rdi_accept & rdi_diff;
   end
   wire logic delta_wr = reg_wr & (reg_addr == poh_monitor_pkg::OFS_DELTA);
   wire logic [poh_monitor_pkg::DELTA_W-1:0] delta_clr =
      delta_wr ? reg_wdata[poh_monitor_pkg::DELTA_W-1:0] : '0;

   // Read decode
   logic [15:0] rd_mux;
   always_comb
   begin
      rd_mux = 16'h0000;
      if (reg_addr == poh_monitor_pkg::OFS_CTRL)
         rd_mux = {8'h00, ctrl_r};
      else if (reg_addr == poh_monitor_pkg::OFS_EXP_LABEL)
         rd_mux = {8'h00, exp_label_r};
      else if (reg_addr == poh_monitor_pkg::OFS_STATUS)
      begin
         rd_mux[poh_monitor_pkg::ST_OOF] = tf_oof_r & sdh;
         rd_mux[poh_monitor_pkg::ST_PLM] = plm_r;
         rd_mux[poh_monitor_pkg::ST_UNEQ] = uneq_r;
         rd_mux[poh_monitor_pkg::ST_RDI_DEFECT] = rdi_def_r & ~sdh;
         rd_mux[poh_monitor_pkg::ST_RDI_LSB +: 3] = rdi_acc_r;
         rd_mux[poh_monitor_pkg::ST_LABEL_LSB +: 8] = label_r;
      end
      else if (reg_addr == poh_monitor_pkg::OFS_DELTA)
         rd_mux = {{(16-poh_monitor_pkg::DELTA_W){1'b0}}, delta_r};
      else if (reg_addr == poh_monitor_pkg::OFS_B3_COUNT)
         rd_mux = b3_count_r;
      else if (reg_addr == poh_monitor_pkg::OFS_REI_COUNT)
         rd_mux = rei_count_r;
      else if (reg_addr[7:6] == poh_monitor_pkg::OFS_STORE_PAGE)
         rd_mux = {8'h00, store_r[reg_addr[5:0]]};
   end

   // Register port; read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ctrl_r <= poh_monitor_pkg::CTRL_RESET;
         exp_label_r <= poh_monitor_pkg::EXP_LABEL_RESET;
         delta_r <= '0;
         rdata_r <= 16'h0000;
      end
      else
      begin
         if (reg_wr & (reg_addr == poh_monitor_pkg::OFS_CTRL))
            ctrl_r <= reg_wdata[7:0];
         if (reg_wr & (reg_addr == poh_monitor_pkg::OFS_EXP_LABEL))
            exp_label_r <= reg_wdata[7:0];
         delta_r <= (delta_r & ~delta_clr) | delta_set;
         rdata_r <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // Trace store: SONET shift capture or SDH accepted frame
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < poh_monitor_pkg::TRACE_LEN; i++)
            store_r[i] <= 8'h00;
      end
      else if (cap_shift)
      begin
         // Oldest byte at entry 0; the tail check sees the last two bytes
         for (int i = 0; i < poh_monitor_pkg::TRACE_LEN - 1; i++)
            store_r[i] <= store_r[i+1];
         store_r[poh_monitor_pkg::TRACE_LEN-1] <= pd;
      end
      else if (sdh_accept)
      begin
         for (int i = 0; i < 16; i++)
            store_r[i] <= frame_nxt[8*i +: 8];
      end
   end

   // SONET capture control; a request in SDH mode is ignored
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         cap_state_r <= poh_monitor_pkg::CAP_IDLE;
         cap_req_prev_r <= 1'b0;
         cap_cnt_r <= 7'h00;
      end
      else
      begin
         cap_req_prev_r <= ctrl_r.capture;
         case (cap_state_r)
            poh_monitor_pkg::CAP_IDLE:
               if (cap_start)
               begin
                  cap_state_r <= poh_monitor_pkg::CAP_RUN;
                  cap_cnt_r <= 7'h00;
               end
            poh_monitor_pkg::CAP_RUN:
               if (sdh | cap_done)
                  cap_state_r <= poh_monitor_pkg::CAP_IDLE;
               else if (cap_shift)
                  cap_cnt_r <= cap_cnt_inc;
            default:
               cap_state_r <= poh_monitor_pkg::CAP_IDLE;
         endcase
      end
   end

   // SDH trace framer; SONET keeps it parked in search
   always_ff @(posedge sys_clk)
   begin
      if (reset | ~sdh)
      begin
         tf_state_r <= poh_monitor_pkg::TF_SEARCH;
         zero_run_r <= 4'h0;
         tf_pos_r <= 4'h0;
         tf_err_r <= 1'b0;
         bad_cnt_r <= 2'h0;
         same_cnt_r <= 2'h0;
         cur_frame_r <= '0;
         prev_frame_r <= '0;
      end
      else if (j1_sdh)
      begin
         case (tf_state_r)
            poh_monitor_pkg::TF_SEARCH:
            begin
               zero_run_r <= pd[7] ? 4'h0 : (zero_run_r == poh_monitor_pkg::SDH_ZERO_RUN) ?
                             zero_run_r : zero_run_r + 4'h1;
               if (go_sync)
               begin
                  tf_state_r <= poh_monitor_pkg::TF_SYNC;
                  tf_pos_r <= 4'h1;
                  tf_err_r <= 1'b0;
                  bad_cnt_r <= 2'h0;
                  same_cnt_r <= 2'h0;
                  cur_frame_r <= frame_nxt;
               end
            end
            poh_monitor_pkg::TF_SYNC:
            begin
               tf_pos_r <= tf_pos_r + 4'h1;
               cur_frame_r <= frame_nxt;
               tf_err_r <= frame_end ? 1'b0 : err_acc;
               if (frame_end)
               begin
                  bad_cnt_r <= bad_nxt;
                  same_cnt_r <= same_nxt;
                  prev_frame_r <= frame_nxt;
               end
               if (lose_sync)
               begin
                  tf_state_r <= poh_monitor_pkg::TF_SEARCH;
                  zero_run_r <= 4'h0;
               end
            end
            default:
               tf_state_r <= poh_monitor_pkg::TF_SEARCH;
         endcase
      end
   end

   // Parity accumulation, error totals and latching
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         latch_prev_r <= 1'b0;
         bip_acc_r <= 8'h00;
         bip_prev_r <= 8'h00;
         acc_ok_r <= 1'b0;
         prev_ok_r <= 1'b0;
         b3_cnt_r <= 16'h0000;
         b3_count_r <= 16'h0000;
         rei_cnt_r <= 16'h0000;
         rei_count_r <= 16'h0000;
         rei_r <= 4'h0;
      end
      else
      begin
         latch_prev_r <= latch_event;
         // J1 opens a frame: the finished parity waits for the next B3
         if (poh.spe & poh.j1)
         begin
            bip_prev_r <= bip_acc_r;
            prev_ok_r <= acc_ok_r;
            bip_acc_r <= pd;
            acc_ok_r <= 1'b1;
         end
         else if (poh.spe)
            bip_acc_r <= bip_acc_r ^ pd;
         if (b3_chk)
            rei_r <= b3_err;
         // On the latch edge this cycle's errors start the new total
         if (latch_edge)
         begin
            b3_count_r <= b3_cnt_r;
            b3_cnt_r <= {12'h000, b3_err};
            rei_count_r <= rei_cnt_r;
            rei_cnt_r <= {12'h000, g1_rei};
         end
         else
         begin
            b3_cnt_r <= add_sat(b3_cnt_r, b3_err);
            rei_cnt_r <= add_sat(rei_cnt_r, g1_rei);
         end
      end
   end

   // Label acceptance and defect flags
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         c2_last_r <= 8'h00;
         c2_cnt_r <= 3'h0;
         label_r <= 8'h00;
         plm_r <= 1'b0;
         uneq_r <= 1'b0;
         rdi_req_r <= 1'b0;
      end
      else
      begin
         if (poh.c2)
         begin
            c2_last_r <= pd;
            c2_cnt_r <= c2_cnt_nxt;
         end
         if (c2_accept)
            label_r <= pd;
         plm_r <= plm_w;
         uneq_r <= uneq_w;
         rdi_req_r <= plm_w | uneq_w;
      end
   end

   // Remote defect acceptance and SONET defect
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rdi_last_r <= 3'h0;
         rdi_cnt_r <= 4'h0;
         rdi_acc_r <= 3'h0;
         on_cnt_r <= 3'h0;
         off_cnt_r <= 3'h0;
         rdi_def_r <= 1'b0;
      end
      else
      begin
         if (poh.g1)
         begin
            rdi_last_r <= rdi_mon;
            rdi_cnt_r <= rdi_cnt_nxt;
         end
         if (rdi_accept)
            rdi_acc_r <= pd[3:1];
         if (sdh)
         begin
            on_cnt_r <= 3'h0;
            off_cnt_r <= 3'h0;
            rdi_def_r <= 1'b0;
         end
         else if (def_step)
         begin
            on_cnt_r <= on_nxt;
            off_cnt_r <= off_nxt;
            if (on_nxt == poh_monitor_pkg::RDI_DEFECT_FRAMES)
               rdi_def_r <= 1'b1;
            else if (off_nxt == poh_monitor_pkg::RDI_DEFECT_FRAMES)
               rdi_def_r <= 1'b0;
         end
      end
   end

   // Out-of-frame flag
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         tf_oof_r <= 1'b0;
      else
         tf_oof_r <= tf_oof_nxt;
   end

   // Outputs straight from flip-flops
   assign reg_rdata = rdata_r;
   assign tx_rei_count = rei_r;
   assign tx_rdi_request = rdi_req_r;

endmodule
`default_nettype wire

// ==== hw/poh_monitor_pkg.sv ====
// Constants, register map and carrier types for the path overhead monitor
package poh_monitor_pkg;

   // Register bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // Register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_EXP_LABEL = 8'h01;
   localparam logic [7:0] OFS_STATUS = 8'h02;
   localparam logic [7:0] OFS_DELTA = 8'h03;
   localparam logic [7:0] OFS_B3_COUNT = 8'h04;
   localparam logic [7:0] OFS_REI_COUNT = 8'h05;
   localparam logic [1:0] OFS_STORE_PAGE = 2'h1;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h50;
   localparam logic [7:0] EXP_LABEL_RESET = 8'h01;

   // Status register field positions
   localparam int ST_OOF = 0;
   localparam int ST_PLM = 1;
   localparam int ST_UNEQ = 2;
   localparam int ST_RDI_DEFECT = 3;
   localparam int ST_RDI_LSB = 4;
   localparam int ST_LABEL_LSB = 8;

   // Delta register bit positions
   localparam int DL_AVAIL = 0;
   localparam int DL_OOF = 1;
   localparam int DL_TRACE = 2;
   localparam int DL_LABEL = 3;
   localparam int DL_PLM = 4;
   localparam int DL_UNEQ = 5;
   localparam int DL_RDI = 6;
   localparam int DELTA_W = 7;

   // Counts
   localparam int TRACE_LEN = 64;
   localparam logic [6:0] TRACE_LEN_CNT = 7'h40;
   localparam logic [3:0] SDH_ZERO_RUN = 4'hf;
   localparam logic [1:0] SDH_BAD_FRAMES = 2'h3;
   localparam logic [1:0] SDH_SAME_FRAMES = 2'h3;
   localparam logic [2:0] LABEL_FRAMES = 3'h5;
   localparam logic [3:0] REI_MAX = 4'h8;
   localparam logic [2:0] RDI_DEFECT_FRAMES = 3'h5;

   // Trace delimiter bytes
   localparam logic [7:0] TRACE_CR = 8'h0d;
   localparam logic [7:0] TRACE_LF = 8'h0a;

   // Exempt labels
   localparam logic [7:0] LABEL_UNEQ = 8'h00;
   localparam logic [7:0] LABEL_EQUIP = 8'h01;
   localparam logic [7:0] LABEL_PDI = 8'hfc;
   localparam logic [7:0] LABEL_RSVD = 8'hff;

   // Byte stream from the upstream pointer interpreter
   typedef struct packed {
      logic [7:0] data;
      logic spe;
      logic j1;
      logic b3;
      logic c2;
      logic g1;
   } poh_in_s;

   // Control register layout
   typedef struct packed {
      logic [3:0] persist;
      logic rdi_sel;
      logic delim;
      logic capture;
      logic sdh;
   } ctrl_s;

   // Trace framer and capture states
   typedef enum logic {TF_SEARCH, TF_SYNC} tf_state_e;
   typedef enum logic {CAP_IDLE, CAP_RUN} cap_state_e;

endpackage

// ==== sim/poh_checker.sv ====
// Port checker for the path overhead monitor
`timescale 1ns/1ps
`default_nettype none
module poh_checker
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Inputs seen at the ports
   input wire poh_monitor_pkg::poh_in_s poh,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   // Outputs under check
   input wire logic [15:0] reg_rdata,
   input wire logic [3:0] tx_rei_count,
   input wire logic tx_rdi_request
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic sdh_r; // Mode bit as last written
   wire st_rd = reg_rd && reg_addr == poh_monitor_pkg::OFS_STATUS;
   // Track the mode so status reads can be judged
   always_ff @(posedge sys_clk)
      if (reset)
         sdh_r <= 1'b0;
      else if (reg_wr && reg_addr == poh_monitor_pkg::OFS_CTRL)
         sdh_r <= reg_wdata[0];
   property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_unmap; reg_rd && reg_addr inside {[8'h06:8'h3f], [8'h80:8'hff]}
      |=> reg_rdata == 16'h0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_rei_max; tx_rei_count <= 4'h8; endproperty
   a_rei_max: assert property (p_rei_max) else $error("parity count above 8");
   property p_rei_hold; !poh.b3 |=> $stable(tx_rei_count); endproperty
   a_rei_hold: assert property (p_rei_hold) else $error("count moved without B3");
   property p_rdi_hold; (!poh.c2 && !reg_wr)[*3] |=> $stable(tx_rdi_request); endproperty
   a_rdi_hold: assert property (p_rdi_hold) else $error("defect request moved");
   property p_excl; st_rd |=> !(reg_rdata[1] && reg_rdata[2]); endproperty
   a_excl: assert property (p_excl) else $error("mismatch with unequipped");
   property p_oof; st_rd && !sdh_r |=> !reg_rdata[0]; endproperty
   a_oof: assert property (p_oof) else $error("trace out of frame in SONET");
   property p_sdh_rdi; st_rd && sdh_r |=> !reg_rdata[3]; endproperty
   a_sdh_rdi: assert property (p_sdh_rdi) else $error("RDI defect in SDH");
   c_plm: cover property (st_rd ##1 reg_rdata[1]);
   c_rei: cover property (tx_rei_count == 4'h3);
   c_rdi: cover property ($rose(tx_rdi_request));
endmodule
bind path_overhead_monitor poh_checker u_chk (.sys_clk(sys_clk), .reset(reset), .poh(poh),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .tx_rei_count(tx_rei_count), .tx_rdi_request(tx_rdi_request));
`default_nettype wire

// ==== sim/poh_source.sv ====
// Upstream byte source: short frames carrying J1, B3, C2 and G1
`timescale 1ns/1ps
`default_nettype none
module poh_source
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Frame request and overhead byte values
   input wire logic go,
   input wire logic [7:0] j1_v,
   input wire logic [7:0] c2_v,
   input wire logic [7:0] g1_v,
   input wire logic [7:0] err_v,
   // Byte stream to the monitor
   output var poh_monitor_pkg::poh_in_s poh,
   output logic busy
);
   logic [3:0] pos_r; // Byte slot, f when idle
   logic [7:0] par_r; // Parity of the frame in flight
   logic [7:0] prev_r; // Parity of the finished frame
   wire [7:0] byte_w = pos_r == 4'h0 ? j1_v : pos_r == 4'h1 ? prev_r ^ err_v :
      pos_r == 4'h2 ? c2_v : pos_r == 4'h3 ? g1_v : {4'h3, pos_r};
   wire spe_w = pos_r < 4'h7; // Seven payload slots, then a gap
   assign busy = pos_r != 4'hf;
   // One slot per clock; gap data toggles so no stale byte lingers
   always_ff @(posedge sys_clk)
      if (reset)
      begin
         pos_r <= 4'hf;
         par_r <= 8'h00;
         prev_r <= 8'h00;
         poh <= '0;
      end
      else
      begin
         pos_r <= busy ? pos_r + 4'h1 : (go ? 4'h0 : 4'hf);
         poh <= {spe_w ? byte_w : ~poh.data, spe_w, pos_r == 4'h0, pos_r == 4'h1,
            pos_r == 4'h2, pos_r == 4'h3};
         if (pos_r == 4'h0)
         begin
            prev_r <= par_r;
            par_r <= byte_w;
         end
         else if (spe_w)
            par_r <= par_r ^ byte_w;
      end
endmodule
`default_nettype wire

// ==== sim/tb_path_overhead_monitor.sv ====
// Self-checking bench for the path overhead monitor
`timescale 1ns/1ps
`default_nettype none
module tb_path_overhead_monitor;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic latch_event = 1'b0;
   logic path_ais = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [3:0] tx_rei_count;
   logic tx_rdi_request;
   logic go = 1'b0;
   logic busy;
   logic [7:0] j1_v = 8'h00, c2_v = 8'h00, g1_v = 8'h00, err_v = 8'h00;
   poh_monitor_pkg::poh_in_s poh;
   int failures = 0;
   int samples_checked = 0;
   int i;
   always #10 sys_clk = ~sys_clk;
   path_overhead_monitor u_dut (.sys_clk(sys_clk), .reset(reset), .poh(poh),
      .latch_event(latch_event), .path_ais(path_ais), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_rei_count(tx_rei_count), .tx_rdi_request(tx_rdi_request));
   poh_source u_src (.sys_clk(sys_clk), .reset(reset), .go(go), .j1_v(j1_v), .c2_v(c2_v),
      .g1_v(g1_v), .err_v(err_v), .poh(poh), .busy(busy));
   task automatic close_out();
      $display("compares %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("ERROR at %0t: saw %h, wanted %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 chk(reg_rdata & m, e);
   endtask
   // One frame from the source; the wait is bounded in case it hangs
   task automatic fr(input logic [7:0] j, input logic [7:0] c, input logic [7:0] g,
      input logic [7:0] e);
      int n;
      @(posedge sys_clk) {j1_v, c2_v, g1_v, err_v, go} <= {j, c, g, e, 1'b1};
      @(posedge sys_clk) go <= 1'b0;
      #1;
      for (n = 0; n < 40 && busy; n++) @(posedge sys_clk) #1;
      if (n == 40)
      begin
         failures++;
         close_out();
      end
   endtask
   task automatic frames(input int n, input logic [7:0] j, input logic [7:0] g);
      for (int k = 0; k < n; k++) fr(j + k[7:0], 8'h00, g, 8'h00);
   endtask
   task automatic latch();
      @(posedge sys_clk) latch_event <= 1'b1;
      repeat (2) @(posedge sys_clk);
      latch_event <= 1'b0;
   endtask
   initial
   begin
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      rc(8'h00, 16'hffff, 16'h0050);
      rc(8'h06, 16'hffff, 16'h0000);
      wr(8'h03, 16'h007f);
      for (i = 0; i < 5; i++) fr(8'h00, 8'h13, 8'h00, 8'h00);
      rc(8'h02, 16'hff06, 16'h1302);
      rc(8'h03, 16'h0038, 16'h0038);
      chk({15'h0, tx_rdi_request}, 16'h0001);
      frames(5, 8'h00, 8'h00);
      rc(8'h02, 16'hff06, 16'h0004);
      wr(8'h01, 16'h0000);
      rc(8'h02, 16'h0006, 16'h0000);
      $display("label test done");
      latch();
      fr(8'h00, 8'h00, 8'h50, 8'h07);
      fr(8'h00, 8'h00, 8'h90, 8'h07);
      fr(8'h00, 8'h00, 8'h80, 8'h07);
      chk({12'h0, tx_rei_count}, 16'h0003);
      latch();
      rc(8'h04, 16'hffff, 16'h0009);
      rc(8'h05, 16'hffff, 16'h000d);
      $display("parity test done");
      wr(8'h03, 16'h007f);
      frames(5, 8'h00, 8'h08);
      rc(8'h02, 16'h0078, 16'h0048);
      rc(8'h03, 16'h0040, 16'h0040);
      @(posedge sys_clk) path_ais <= 1'b1;
      frames(5, 8'h00, 8'h00);
      rc(8'h02, 16'h0008, 16'h0008);
      @(posedge sys_clk) path_ais <= 1'b0;
      frames(5, 8'h00, 8'h00);
      rc(8'h02, 16'h0078, 16'h0000);
      $display("defect test done");
      wr(8'h00, 16'h0052);
      wr(8'h03, 16'h007f);
      frames(64, 8'h00, 8'h00);
      rc(8'h03, 16'h0001, 16'h0001);
      rc(8'h40, 16'hffff, 16'h0000);
      rc(8'h7f, 16'hffff, 16'h003f);
      wr(8'h00, 16'h0050);
      wr(8'h00, 16'h0056);
      wr(8'h03, 16'h007f);
      frames(70, 8'h00, 8'h00);
      rc(8'h03, 16'h0001, 16'h0000);
      fr(8'h0d, 8'h00, 8'h00, 8'h00);
      fr(8'h0a, 8'h00, 8'h00, 8'h00);
      rc(8'h03, 16'h0001, 16'h0001);
      rc(8'h40, 16'hffff, 16'h0008);
      $display("capture test done");
      wr(8'h00, 16'h0051);
      wr(8'h03, 16'h007f);
      rc(8'h02, 16'h0001, 16'h0001);
      for (i = 0; i < 80; i++) fr(i[3:0] == 4'h0 ? 8'h8c : {4'h0, i[3:0]}, 8'h0, 8'h0, 8'h0);
      rc(8'h02, 16'h0001, 16'h0000);
      rc(8'h03, 16'h0006, 16'h0006);
      rc(8'h4f, 16'hffff, 16'h008c);
      rc(8'h40, 16'hffff, 16'h0001);
      frames(48, 8'h01, 8'h00);
      rc(8'h02, 16'h0001, 16'h0001);
      $display("trace frame test done");
      close_out();
   end
endmodule
`default_nettype wire
